/* File: rtl/port9_pkg.sv */
// shared constants for the port 9 pin mode select block
package port9_pkg;

	// ==========================================================
	// register map (printed offsets are word indices)
	// ==========================================================
	localparam logic [31:0] MODE_CTRL_INDEX      = 32'hfffff452;
	localparam logic [31:0] MODE_CTRL_HIGH_INDEX = 32'hfffff453;

	// ==========================================================
	// mode register layout
	// ==========================================================
	localparam int          MODE_W          = 16;
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [15:0] MODE_IMPL_MASK  = 16'he3c3;
	localparam logic [31:0] BUS_READ_IDLE   = 32'h0000_0000;

	// pin positions inside the mode register
	localparam int PIN_ASYNC_TX  = 0;
	localparam int PIN_ASYNC_RX  = 1;
	localparam int PIN_TIMER_B   = 6;
	localparam int PIN_CSI_IN    = 7;
	localparam int PIN_CSI_OUT   = 8;
	localparam int PIN_CSI_CLOCK = 9;
	localparam int PIN_IRQ_A     = 13;
	localparam int PIN_IRQ_B     = 14;
	localparam int PIN_IRQ_C     = 15;

	// pin drive defaults after reset: released, driving low level
	localparam logic [15:0] PIN_OE_N_RESET = 16'hffff;
	localparam logic [15:0] PIN_OUT_RESET  = 16'h0000;

endpackage : port9_pkg

/* File: rtl/port9_pin_route.sv */
// per-pin routing between port logic and alternate peripherals
`timescale 1ns/1ps
`default_nettype none

module port9_pin_route #(
	parameter int PINS = 16
) (
	input  wire logic [PINS-1:0] mode_i,
	input  wire logic [PINS-1:0] pin_in_i,
	input  wire logic [PINS-1:0] port_out_i,
	input  wire logic [PINS-1:0] port_dir_out_i,
	input  wire logic            async_transmit_out_i,
	input  wire logic            csi_serial_out_i,
	input  wire logic            csi_serial_clock_out_i,
	input  wire logic            csi_serial_clock_oe_i,
	input  wire logic            timer_b_output_i,
	output logic      [PINS-1:0] pin_out_o,
	output logic      [PINS-1:0] pin_oe_n_o,
	output logic      [PINS-1:0] port_in_o,
	output logic                 async_receive_in_o,
	output logic                 csi_serial_in_o,
	output logic                 csi_serial_clock_in_o,
	output logic                 timer_b_input_o,
	output logic      [1:0]      key_return_in_o,
	output logic      [2:0]      ext_irq_in_o
);

	if (PINS != port9_pkg::MODE_W)
	begin : g_bad_pins
		$error("port9_pin_route: PINS must equal the mode register width");
	end

	always_comb
	begin
		// port mode by default; unimplemented pins stay released
		pin_out_o  = port_out_i & port9_pkg::MODE_IMPL_MASK;
		pin_oe_n_o = ~(port_dir_out_i & port9_pkg::MODE_IMPL_MASK & ~mode_i);
		port_in_o  = pin_in_i & port9_pkg::MODE_IMPL_MASK & ~mode_i;

		// alternate outputs take the pin whenever their bit is set
		if (mode_i[port9_pkg::PIN_ASYNC_TX])
		begin
			pin_out_o[port9_pkg::PIN_ASYNC_TX]  = async_transmit_out_i;
			pin_oe_n_o[port9_pkg::PIN_ASYNC_TX] = 1'b0;
		end
		if (mode_i[port9_pkg::PIN_TIMER_B])
		begin
			pin_out_o[port9_pkg::PIN_TIMER_B]  = timer_b_output_i;
			pin_oe_n_o[port9_pkg::PIN_TIMER_B] = 1'b0;
		end
		if (mode_i[port9_pkg::PIN_CSI_OUT])
		begin
			pin_out_o[port9_pkg::PIN_CSI_OUT]  = csi_serial_out_i;
			pin_oe_n_o[port9_pkg::PIN_CSI_OUT] = 1'b0;
		end
		// serial clock is two-way: the channel decides who drives
		if (mode_i[port9_pkg::PIN_CSI_CLOCK])
		begin
			pin_out_o[port9_pkg::PIN_CSI_CLOCK]  = csi_serial_clock_out_i;
			pin_oe_n_o[port9_pkg::PIN_CSI_CLOCK] = ~csi_serial_clock_oe_i;
		end
		// alternate inputs see the pin only when selected
		async_receive_in_o    = mode_i[port9_pkg::PIN_ASYNC_RX] & pin_in_i[port9_pkg::PIN_ASYNC_RX];
		csi_serial_in_o       = mode_i[port9_pkg::PIN_CSI_IN] & pin_in_i[port9_pkg::PIN_CSI_IN];
		csi_serial_clock_in_o = mode_i[port9_pkg::PIN_CSI_CLOCK] & pin_in_i[port9_pkg::PIN_CSI_CLOCK];
		ext_irq_in_o          = mode_i[port9_pkg::PIN_IRQ_C:port9_pkg::PIN_IRQ_A]
			& pin_in_i[port9_pkg::PIN_IRQ_C:port9_pkg::PIN_IRQ_A];
		// timer input and key returns share pins with port mode
		timer_b_input_o    = ~mode_i[port9_pkg::PIN_TIMER_B] & pin_in_i[port9_pkg::PIN_TIMER_B];
		key_return_in_o[0] = ~mode_i[port9_pkg::PIN_ASYNC_TX] & pin_in_i[port9_pkg::PIN_ASYNC_TX];
		key_return_in_o[1] = ~mode_i[port9_pkg::PIN_ASYNC_RX] & pin_in_i[port9_pkg::PIN_ASYNC_RX];
	end

endmodule : port9_pin_route

`default_nettype wire

/* File: rtl/port9_pin_mode_select.sv */
// port 9 mode control register with wishbone slave and pin routing
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module port9_pin_mode_select #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone classic slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	// port side
	input  wire logic [15:0]       pin_in_i,
	input  wire logic [15:0]       port_out_i,
	input  wire logic [15:0]       port_dir_out_i,
	output logic      [15:0]       pin_out_o,
	output logic      [15:0]       pin_oe_n_o,
	output logic      [15:0]       port_in_o,
	output logic      [15:0]       port9_mode_ctrl_o,
	// peripheral side
	input  wire logic              async_transmit_out_i,
	input  wire logic              csi_serial_out_i,
	input  wire logic              csi_serial_clock_out_i,
	input  wire logic              csi_serial_clock_oe_i,
	input  wire logic              timer_b_output_i,
	output logic                   async_receive_in_o,
	output logic                   csi_serial_in_o,
	output logic                   csi_serial_clock_in_o,
	output logic                   timer_b_input_o,
	output logic      [1:0]        key_return_in_o,
	output logic      [2:0]        ext_irq_in_o
);

	if (ADDR_W < 3 || ADDR_W > 32)
	begin : g_bad_addr
		$error("port9_pin_mode_select: ADDR_W must lie in 3..32");
	end

	// ==========================================================
	// address decode
	// ==========================================================
	function automatic logic word_hit(input logic [ADDR_W-1:0] adr, input logic [31:0] index);
		word_hit = (adr[ADDR_W-1:2] == index[ADDR_W-3:0]);
	endfunction : word_hit

	logic [15:0] port9_mode_ctrl;
	logic [15:0] next_port9_mode_ctrl;
	logic [31:0] next_dat;
	logic        next_ack;
	logic        req;
	logic        hit_full;
	logic        hit_high;

	assign req      = cyc_i & stb_i & ~ack_o;
	assign hit_full = word_hit(adr_i, port9_pkg::MODE_CTRL_INDEX);
	assign hit_high = word_hit(adr_i, port9_pkg::MODE_CTRL_HIGH_INDEX);

	// ==========================================================
	// register and bus answer
	// ==========================================================
	always_comb
	begin
		next_port9_mode_ctrl = port9_mode_ctrl;
		next_dat             = port9_pkg::BUS_READ_IDLE;
		// one wait state, ack held a single cycle
		next_ack             = req;
		if (req && we_i)
		begin
			if (hit_full)
			begin
				// lane 0 is the low view, lane 1 the upper bits
				if (sel_i[0])
					next_port9_mode_ctrl[7:0] = dat_i[7:0];
				if (sel_i[1])
					next_port9_mode_ctrl[15:8] = dat_i[15:8];
			end
			else if (hit_high && sel_i[0])
				next_port9_mode_ctrl[15:8] = dat_i[7:0];
		end
		// unimplemented positions never hold a one
		next_port9_mode_ctrl = next_port9_mode_ctrl & port9_pkg::MODE_IMPL_MASK;
		if (req && !we_i)
		begin
			if (hit_full)
				next_dat = {16'h0000, port9_mode_ctrl};
			else if (hit_high)
				next_dat = {24'h00_0000, port9_mode_ctrl[15:8]};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			port9_mode_ctrl <= port9_pkg::MODE_RESET;
			dat_o           <= port9_pkg::BUS_READ_IDLE;
			ack_o           <= 1'b0;
		end
		else
		begin
			port9_mode_ctrl <= next_port9_mode_ctrl;
			dat_o           <= next_dat;
			ack_o           <= next_ack;
		end
	end

	// ==========================================================
	// pin routing
	// ==========================================================
	logic [15:0] route_pin_out;
	logic [15:0] route_pin_oe_n;
	logic [15:0] route_port_in;
	logic        route_async_rx;
	logic        route_csi_in;
	logic        route_csi_clock_in;
	logic        route_timer_in;
	logic [1:0]  route_key;
	logic [2:0]  route_irq;

	port9_pin_route #(
		.PINS (16)
	) u_route (
		.mode_i                 (port9_mode_ctrl),
		.pin_in_i               (pin_in_i),
		.port_out_i             (port_out_i),
		.port_dir_out_i         (port_dir_out_i),
		.async_transmit_out_i   (async_transmit_out_i),
		.csi_serial_out_i       (csi_serial_out_i),
		.csi_serial_clock_out_i (csi_serial_clock_out_i),
		.csi_serial_clock_oe_i  (csi_serial_clock_oe_i),
		.timer_b_output_i       (timer_b_output_i),
		.pin_out_o              (route_pin_out),
		.pin_oe_n_o             (route_pin_oe_n),
		.port_in_o              (route_port_in),
		.async_receive_in_o     (route_async_rx),
		.csi_serial_in_o        (route_csi_in),
		.csi_serial_clock_in_o  (route_csi_clock_in),
		.timer_b_input_o        (route_timer_in),
		.key_return_in_o        (route_key),
		.ext_irq_in_o           (route_irq)
	);

	// registered so every output leaves a flop; costs one cycle of pin latency
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_out_o             <= port9_pkg::PIN_OUT_RESET;
			pin_oe_n_o            <= port9_pkg::PIN_OE_N_RESET;
			port_in_o             <= 16'h0000;
			port9_mode_ctrl_o     <= port9_pkg::MODE_RESET;
			async_receive_in_o    <= 1'b0;
			csi_serial_in_o       <= 1'b0;
			csi_serial_clock_in_o <= 1'b0;
			timer_b_input_o       <= 1'b0;
			key_return_in_o       <= 2'h0;
			ext_irq_in_o          <= 3'h0;
		end
		else
		begin
			pin_out_o             <= route_pin_out;
			pin_oe_n_o            <= route_pin_oe_n;
			port_in_o             <= route_port_in;
			port9_mode_ctrl_o     <= port9_mode_ctrl;
			async_receive_in_o    <= route_async_rx;
			csi_serial_in_o       <= route_csi_in;
			csi_serial_clock_in_o <= route_csi_clock_in;
			timer_b_input_o       <= route_timer_in;
			key_return_in_o       <= route_key;
			ext_irq_in_o          <= route_irq;
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	a_high_alias_write: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && hit_high && !hit_full && sel_i[0]
		|=> port9_mode_ctrl[15:8] == ($past(dat_i[7:0]) & port9_pkg::MODE_IMPL_MASK[15:8]))
		else $error("high alias write did not reach bits 15..8");

	a_high_alias_read: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_high && !hit_full
		|=> ack_o && dat_o == {24'h00_0000, $past(port9_mode_ctrl[15:8])})
		else $error("high alias read returned wrong data");

	a_halfword_access: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && hit_full && sel_i[1:0] == 2'h3
		|=> port9_mode_ctrl == ($past(dat_i[15:0]) & port9_pkg::MODE_IMPL_MASK)
		##1 !ack_o)
		else $error("halfword write or ack length wrong");

	a_low_byte_only: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && hit_full && sel_i[1:0] == 2'h1
		|=> port9_mode_ctrl[15:8] == $past(port9_mode_ctrl[15:8])
		&& port9_mode_ctrl[7:0] == ($past(dat_i[7:0]) & port9_pkg::MODE_IMPL_MASK[7:0]))
		else $error("low byte write disturbed the high byte");

	a_tx_pin_select: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(port9_mode_ctrl[port9_pkg::PIN_ASYNC_TX])
		|-> !pin_oe_n_o[port9_pkg::PIN_ASYNC_TX]
		&& pin_out_o[port9_pkg::PIN_ASYNC_TX] == $past(async_transmit_out_i))
		else $error("transmit output not on pin 0");

	a_port_mode_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && !$past(port9_mode_ctrl[port9_pkg::PIN_CSI_OUT])
		|-> pin_oe_n_o[port9_pkg::PIN_CSI_OUT] == !$past(port_dir_out_i[port9_pkg::PIN_CSI_OUT]))
		else $error("pin 8 in port mode not following direction");

	a_csi_out_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(port9_mode_ctrl[port9_pkg::PIN_CSI_OUT])
		|-> !pin_oe_n_o[port9_pkg::PIN_CSI_OUT]
		&& pin_out_o[port9_pkg::PIN_CSI_OUT] == $past(csi_serial_out_i))
		else $error("serial output not on pin 8");

	a_irq_gating: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> ext_irq_in_o == ($past(port9_mode_ctrl[15:13]) & $past(pin_in_i[15:13])))
		else $error("interrupt inputs not gated by mode bits");

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(port9_mode_ctrl & ~port9_pkg::MODE_IMPL_MASK) == 16'h0000
		&& (!ack_o || (dat_o[31:16] == 16'h0000)))
		else $error("reserved mode bits not zero");

endmodule : port9_pin_mode_select

`default_nettype wire

/* File: dv/port9_pin_mode_select_test.sv */
// self-checking bench for the port 9 pin mode select block
`timescale 1ns/1ps
`default_nettype none

module port9_pin_mode_select_test;

	// ==========================================================
	// stimulus and design
	// ==========================================================
	localparam logic [7:0] A_FULL = 8'(port9_pkg::MODE_CTRL_INDEX << 2);
	localparam logic [7:0] A_HIGH = 8'(port9_pkg::MODE_CTRL_HIGH_INDEX << 2);
	localparam logic [7:0] A_NONE = 8'h00;
	// pins that the block drives in alternate mode
	localparam logic [15:0] ALT_OUT = 16'h0341;

	logic        clk_i;
	logic        rst_i;
	logic        cyc, stb, we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, dat_o;
	logic        ack_o;
	logic [15:0] pin_in, port_out, port_dir;
	logic [15:0] pin_out_o, pin_oe_n_o, port_in_o, mode_o;
	logic        tx, so, sck, sck_oe, tmr;
	logic        rx_o, si_o, sck_in_o, tmr_in_o;
	logic [1:0]  key_o;
	logic [2:0]  irq_o;
	int          mismatches;
	int          total_checks;

	port9_pin_mode_select #(.ADDR_W(8)) i_port9_pin_mode_select (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .pin_in_i(pin_in),
		.port_out_i(port_out), .port_dir_out_i(port_dir), .pin_out_o(pin_out_o),
		.pin_oe_n_o(pin_oe_n_o), .port_in_o(port_in_o), .port9_mode_ctrl_o(mode_o),
		.async_transmit_out_i(tx), .csi_serial_out_i(so), .csi_serial_clock_out_i(sck),
		.csi_serial_clock_oe_i(sck_oe), .timer_b_output_i(tmr), .async_receive_in_o(rx_o),
		.csi_serial_in_o(si_o), .csi_serial_clock_in_o(sck_in_o), .timer_b_input_o(tmr_in_o),
		.key_return_in_o(key_o), .ext_irq_in_o(irq_o)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ==========================================================
	// shared tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// classic cycle; ack and read data are taken at the edge that sees ack high
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h0bad, 32'h0ac0);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic settle();
		repeat (3) @(posedge clk_i);
	endtask : settle

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_regs();
		wb(1'b0, A_FULL, 4'h3, 32'h0); chk(rdat, 32'h0);
		wb(1'b1, A_FULL, 4'h3, 32'hffff); wb(1'b0, A_FULL, 4'h3, 32'h0);
		chk(rdat, 32'he3c3);
		wb(1'b0, A_HIGH, 4'h1, 32'h0); chk(rdat, 32'he3);
		wb(1'b1, A_HIGH, 4'h1, 32'h00); wb(1'b0, A_FULL, 4'h3, 32'h0);
		chk(rdat, 32'h00c3);
		wb(1'b1, A_FULL, 4'h2, 32'ha100); wb(1'b0, A_FULL, 4'h3, 32'h0);
		chk(rdat, 32'ha1c3);
		wb(1'b1, A_FULL, 4'h1, 32'h0000); wb(1'b1, A_FULL, 4'hc, 32'hffffffff);
		wb(1'b0, A_FULL, 4'h3, 32'h0); chk(rdat, 32'ha100);
		// single-bit set of pin 9 through the high view
		wb(1'b0, A_HIGH, 4'h1, 32'h0);
		wb(1'b1, A_HIGH, 4'h1, rdat | 32'h02); wb(1'b0, A_FULL, 4'h3, 32'h0);
		chk(rdat, 32'ha300);
		wb(1'b1, A_NONE, 4'hf, 32'hffffffff); wb(1'b0, A_NONE, 4'hf, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, A_FULL, 4'h3, 32'h0); chk(rdat, 32'ha300);
		$display("register views test done");
	endtask : t_regs

	task automatic t_pins();
		pin_in   <= 16'hffff;
		port_out <= 16'hffff;
		port_dir <= 16'hffff;
		tx <= 1'b1; so <= 1'b1; sck <= 1'b1; sck_oe <= 1'b1; tmr <= 1'b1;
		wb(1'b1, A_FULL, 4'h3, 32'h0000); settle();
		chk(32'(pin_out_o), 32'he3c3);
		chk(32'(pin_oe_n_o), 32'h1c3c);
		chk(32'(port_in_o & 16'he3c3), 32'he3c3);
		chk(32'({tmr_in_o, key_o, irq_o, rx_o, si_o}), 32'he0);
		wb(1'b1, A_FULL, 4'h3, 32'hffff); settle();
		chk(32'(mode_o), 32'he3c3);
		chk(32'(pin_oe_n_o & ALT_OUT), 32'h0);
		chk(32'({rx_o, si_o, sck_in_o, irq_o, tmr_in_o, key_o}), 32'h1f8);
		chk(32'(port_in_o & 16'he3c3), 32'h0);
		// port latch stays high so only the peripheral levels can pull these pins low
		tx <= 1'b0; so <= 1'b0; sck <= 1'b0; sck_oe <= 1'b0; tmr <= 1'b0;
		settle();
		chk(32'(pin_out_o & ALT_OUT), 32'h0);
		chk(32'(pin_oe_n_o & ALT_OUT), 32'h0200);
		pin_in <= 16'h0000;
		settle();
		chk(32'({rx_o, si_o, sck_in_o, irq_o}), 32'h0);
		$display("pin routing test done");
	endtask : t_pins

	// mid-run reset must clear the mode register and release the pins
	task automatic t_reset();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(pin_oe_n_o), 32'hffff);
		chk(32'(mode_o), 32'h0);
		wb(1'b0, A_FULL, 4'h3, 32'h0); chk(rdat, 32'h0);
		$display("reset test done");
	endtask : t_reset

	// ==========================================================
	// main sequence and watchdog
	// ==========================================================
	initial
	begin
		mismatches = 0;
		total_checks = 0;
		rst_i = 1'b1;
		{cyc, stb, we, sel, adr, dat} = '0;
		{pin_in, port_out, port_dir} = '0;
		{tx, so, sck, sck_oe, tmr} = '0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(pin_oe_n_o), 32'hffff);
		t_regs();
		t_pins();
		t_reset();
		wrap_up();
	end

	initial
	begin
		repeat (2000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end

endmodule : port9_pin_mode_select_test

`default_nettype wire
